// *** logic/video_test_pattern_control.sv ***
// test pattern control: timing choice, colour invert, auto scroll, indirect registers
// Operation
// - timing select 0 takes external clock enable, data enable and syncs; reset default
// - timing select 1 runs internal timing from programmed frame and sync settings
// - colour invert bit 1 inverts generated colour, 0 passes it unchanged
// - auto scroll 0 holds the selected pattern indefinitely
// - auto scroll 1 steps to next enabled pattern after frame-time frames
// - index register at 0x66, eight bits, read-write, resets to zero
// - write to 0x67 stores the byte into the indexed internal register
// - read of 0x67 returns the indexed internal register contents
// - external clock bit picks pixel rate under internal timing only
`timescale 1ns/1ps
module video_test_pattern_control
	import pattern_ctrl_pkg::*;
#(
	parameter int DIV_RATIO = 4
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic ext_pclk_en,
	input wire logic ext_de,
	input wire logic ext_hs,
	input wire logic ext_vs,
	input wire logic [23:0] pattern_rgb,
	output logic pix_valid,
	output logic pix_de,
	output logic pix_hs,
	output logic pix_vs,
	output logic [23:0] pix_rgb,
	output logic [2:0] pattern_sel
);
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] index;
		logic [IND_DEPTH*8-1:0] ind;
		logic [7:0] rdata;
		logic [7:0] frames;
		logic [$clog2(DIV_RATIO)-1:0] div;
		logic ext_vs_d;
		logic valid;
		logic de;
		logic hs;
		logic vs;
		logic [23:0] rgb;
	} ctrl_t;
	ctrl_t st_reg;
	ctrl_t st_next;
	timing_if tif();
	timing_engine u_engine (
		.clk(clk),
		.rst_n(rst_n),
		.tif(tif)
	);
	function automatic logic [7:0] ind_byte(input logic [IND_DEPTH*8-1:0] m, input logic [7:0] a);
		return m[a[3:0]*8 +: 8];
	endfunction
	function automatic logic [2:0] next_pat(input logic [2:0] cur, input logic [7:0] en);
		logic [2:0] n;
		n = cur;
		for (int i = PAT_COUNT - 1; i >= 1; i--)
		begin
			if (en[3'(cur + 3'(i))])
				n = 3'(cur + 3'(i));
		end
		return n;
	endfunction
	logic int_mode;
	logic src_step;
	logic src_de;
	logic src_hs;
	logic src_vs;
	logic frame_done;
	logic div_tick;
	logic [2:0] cur_pat;
	assign int_mode = st_reg.cfg[BIT_TIMING_SEL];
	assign cur_pat = st_reg.ind[IND_PAT_SELECT[3:0]*8 +: 3];
	assign tif.h_total = {ind_byte(st_reg.ind, IND_H_TOTAL_HI),
		ind_byte(st_reg.ind, IND_H_TOTAL_LO)};
	assign tif.v_total = {ind_byte(st_reg.ind, IND_V_TOTAL_HI),
		ind_byte(st_reg.ind, IND_V_TOTAL_LO)};
	assign tif.h_active = {ind_byte(st_reg.ind, IND_H_ACTIVE_HI),
		ind_byte(st_reg.ind, IND_H_ACTIVE_LO)};
	assign tif.v_active = {ind_byte(st_reg.ind, IND_V_ACTIVE_HI),
		ind_byte(st_reg.ind, IND_V_ACTIVE_LO)};
	assign tif.h_sync_w = ind_byte(st_reg.ind, IND_H_SYNC_W);
	assign tif.v_sync_w = ind_byte(st_reg.ind, IND_V_SYNC_W);
	assign tif.h_bporch = ind_byte(st_reg.ind, IND_H_BPORCH);
	assign tif.v_bporch = ind_byte(st_reg.ind, IND_V_BPORCH);
	assign tif.sync_pol = st_reg.ind[IND_SYNC_CFG[3:0]*8 +: 2];
	assign tif.run = int_mode;
	// divided internal rate unless external clock picked; bit ignored in external mode
	assign div_tick = st_reg.div == '0;
	assign tif.step = st_reg.cfg[BIT_EXT_CLOCK] ? ext_pclk_en : div_tick;
	always_comb
	begin
		st_next = st_reg;
		if (int_mode)
		begin
			src_step = tif.step;
			src_de = tif.de;
			src_hs = tif.hs;
			src_vs = tif.vs;
			frame_done = tif.frame_end;
		end
		else
		begin
			src_step = ext_pclk_en;
			src_de = ext_de;
			src_hs = ext_hs;
			src_vs = ext_vs;
			frame_done = ext_pclk_en && ext_vs && !st_reg.ext_vs_d;
		end
		st_next.div = div_tick ? ($clog2(DIV_RATIO))'(DIV_RATIO - 1) : st_reg.div - 1'b1;
		if (ext_pclk_en)
			st_next.ext_vs_d = ext_vs;
		st_next.valid = src_step;
		if (src_step)
		begin
			st_next.de = src_de;
			st_next.hs = src_hs;
			st_next.vs = src_vs;
			st_next.rgb = st_reg.cfg[BIT_COLOR_INVERT] ? ~pattern_rgb : pattern_rgb;
		end
		// auto scroll: frame count per active-source frame, restart on change
		if (!st_reg.cfg[BIT_AUTO_SCROLL])
			st_next.frames = '0;
		else if (frame_done)
		begin
			if (st_reg.frames + 8'd1 >= ind_byte(st_reg.ind, IND_FRAME_TIME))
			begin
				st_next.frames = '0;
				st_next.ind[IND_PAT_SELECT[3:0]*8 +: 3] = next_pat(cur_pat,
					ind_byte(st_reg.ind, IND_PAT_ENABLE));
			end
			else
			begin
				st_next.frames = st_reg.frames + 8'd1;
			end
		end
		if (reg_wr)
		begin
			case (reg_addr)
				OFF_PATGEN_CFG: st_next.cfg = reg_wdata;
				OFF_INDEX_ADDR: st_next.index = reg_wdata;
				OFF_INDEX_DATA:
				begin
					// host write wins over a same-cycle auto step
					if (st_reg.index < 8'(IND_DEPTH))
						st_next.ind[st_reg.index[3:0]*8 +: 8] = reg_wdata;
					if (st_reg.index == IND_PAT_SELECT)
						st_next.frames = '0;
				end
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				OFF_PATGEN_CFG: st_next.rdata = st_reg.cfg;
				OFF_INDEX_ADDR: st_next.rdata = st_reg.index;
				OFF_INDEX_DATA: st_next.rdata = (st_reg.index < 8'(IND_DEPTH)) ?
					ind_byte(st_reg.ind, st_reg.index) : 8'h00;
				default: st_next.rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.cfg <= CFG_RESET;
			st_reg.index <= INDEX_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end
	assign reg_rdata = st_reg.rdata;
	assign pix_valid = st_reg.valid;
	assign pix_de = st_reg.de;
	assign pix_hs = st_reg.hs;
	assign pix_vs = st_reg.vs;
	assign pix_rgb = st_reg.rgb;
	assign pattern_sel = cur_pat;
endmodule

// *** include/pattern_ctrl_pkg.sv ***
// constants and state types shared by the pattern control block
package pattern_ctrl_pkg;
	localparam logic [7:0] OFF_PATGEN_CFG = 8'h65;
	localparam logic [7:0] OFF_INDEX_ADDR = 8'h66;
	localparam logic [7:0] OFF_INDEX_DATA = 8'h67;
	localparam int BIT_AUTO_SCROLL = 0;
	localparam int BIT_COLOR_INVERT = 1;
	localparam int BIT_TIMING_SEL = 2;
	localparam int BIT_EXT_CLOCK = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	// indirect map: timing settings, then frame time, then pattern enables
	localparam logic [7:0] IND_H_TOTAL_LO = 8'h00;
	localparam logic [7:0] IND_H_TOTAL_HI = 8'h01;
	localparam logic [7:0] IND_V_TOTAL_LO = 8'h02;
	localparam logic [7:0] IND_V_TOTAL_HI = 8'h03;
	localparam logic [7:0] IND_H_ACTIVE_LO = 8'h04;
	localparam logic [7:0] IND_H_ACTIVE_HI = 8'h05;
	localparam logic [7:0] IND_V_ACTIVE_LO = 8'h06;
	localparam logic [7:0] IND_V_ACTIVE_HI = 8'h07;
	localparam logic [7:0] IND_H_SYNC_W = 8'h08;
	localparam logic [7:0] IND_V_SYNC_W = 8'h09;
	localparam logic [7:0] IND_H_BPORCH = 8'h0A;
	localparam logic [7:0] IND_V_BPORCH = 8'h0B;
	localparam logic [7:0] IND_SYNC_CFG = 8'h0C;
	localparam logic [7:0] IND_FRAME_TIME = 8'h0D;
	localparam logic [7:0] IND_PAT_ENABLE = 8'h0E;
	localparam logic [7:0] IND_PAT_SELECT = 8'h0F;
	localparam int IND_DEPTH = 16;
	localparam int PAT_COUNT = 8;
	typedef enum logic [1:0] {S_ACTIVE, S_FPORCH, S_SYNC, S_BPORCH} line_state_t;
endpackage

// *** include/timing_if.sv ***
// timing settings and frame output carried between the control and the timing engine
`timescale 1ns/1ps
interface timing_if;
	logic [15:0] h_total;
	logic [15:0] v_total;
	logic [15:0] h_active;
	logic [15:0] v_active;
	logic [7:0] h_sync_w;
	logic [7:0] v_sync_w;
	logic [7:0] h_bporch;
	logic [7:0] v_bporch;
	logic [1:0] sync_pol;
	logic step;
	logic run;
	logic de;
	logic hs;
	logic vs;
	logic frame_end;
	modport ctrl (output h_total, v_total, h_active, v_active, h_sync_w, v_sync_w,
		h_bporch, v_bporch, sync_pol, step, run, input de, hs, vs, frame_end);
	modport engine (input h_total, v_total, h_active, v_active, h_sync_w, v_sync_w,
		h_bporch, v_bporch, sync_pol, step, run, output de, hs, vs, frame_end);
endinterface

// *** logic/timing_engine.sv ***
// self-generated raster timing counters
`timescale 1ns/1ps
module timing_engine
	import pattern_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	timing_if.engine tif
);
	typedef struct packed {
		logic [15:0] hcnt;
		logic [15:0] vcnt;
		logic de;
		logic hs;
		logic vs;
		logic frame_end;
	} eng_t;
	eng_t st_reg;
	eng_t st_next;
	logic [15:0] hs_start;
	logic [15:0] vs_start;
	always_comb
	begin
		st_next = st_reg;
		st_next.frame_end = 1'b0;
		// sync sits just before back porch, which ends at the total
		hs_start = tif.h_total - 16'(tif.h_bporch) - 16'(tif.h_sync_w);
		vs_start = tif.v_total - 16'(tif.v_bporch) - 16'(tif.v_sync_w);
		if (!tif.run)
		begin
			st_next.hcnt = '0;
			st_next.vcnt = '0;
		end
		else if (tif.step)
		begin
			if (st_reg.hcnt + 16'd1 >= tif.h_total)
			begin
				st_next.hcnt = '0;
				if (st_reg.vcnt + 16'd1 >= tif.v_total)
				begin
					st_next.vcnt = '0;
					st_next.frame_end = 1'b1;
				end
				else
				begin
					st_next.vcnt = st_reg.vcnt + 16'd1;
				end
			end
			else
			begin
				st_next.hcnt = st_reg.hcnt + 16'd1;
			end
		end
		st_next.de = tif.run && st_next.hcnt < tif.h_active && st_next.vcnt < tif.v_active;
		st_next.hs = (tif.run && st_next.hcnt >= hs_start && st_next.hcnt < hs_start
			+ 16'(tif.h_sync_w)) ^ tif.sync_pol[0];
		st_next.vs = (tif.run && st_next.vcnt >= vs_start && st_next.vcnt < vs_start
			+ 16'(tif.v_sync_w)) ^ tif.sync_pol[1];
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign tif.de = st_reg.de;
	assign tif.hs = st_reg.hs;
	assign tif.vs = st_reg.vs;
	assign tif.frame_end = st_reg.frame_end;
endmodule

// *** tb/video_test_pattern_control_assertions.sv ***
// port-level assertions for the pattern control block
`timescale 1ns/1ps
module video_test_pattern_control_assertions
	import pattern_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic ext_pclk_en,
	input wire logic ext_de,
	input wire logic [23:0] pattern_rgb,
	input wire logic pix_valid,
	input wire logic pix_de,
	input wire logic [23:0] pix_rgb,
	input wire logic [2:0] pattern_sel
);
	logic [7:0] cfg_reg;
	logic [7:0] idx_reg;
	// shadows rebuilt from bus writes, so they switch on the same edge as the design
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			cfg_reg <= 8'h00;
			idx_reg <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == OFF_PATGEN_CFG)
				cfg_reg <= reg_wdata;
			if (reg_addr == OFF_INDEX_ADDR)
				idx_reg <= reg_wdata;
		end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire ext_mode = !cfg_reg[BIT_TIMING_SEL];
	wire data_wr = reg_wr && reg_addr == OFF_INDEX_DATA;
	sequence sel_index_load;
		reg_wr && reg_addr == OFF_INDEX_ADDR && reg_wdata == IND_PAT_SELECT;
	endsequence
	sequence sel_data_write;
		reg_wr && reg_addr == OFF_INDEX_DATA;
	endsequence
	ext_step_a: assert property (ext_mode && ext_pclk_en |=>
		pix_valid && pix_de == $past(ext_de))
		else $error("external step lost");
	ext_idle_a: assert property (ext_mode && !ext_pclk_en |=> !pix_valid)
		else $error("step without enable");
	color_inv_a: assert property (ext_mode && ext_pclk_en |=>
		pix_rgb == ($past(pattern_rgb) ^ {24{$past(cfg_reg[BIT_COLOR_INVERT])}}))
		else $error("colour mismatch");
	hold_sel_a: assert property (!cfg_reg[BIT_AUTO_SCROLL] && !data_wr |=> $stable(pattern_sel))
		else $error("pattern moved");
	sel_write_a: assert property (sel_index_load ##1 sel_data_write |=>
		pattern_sel == $past(reg_wdata[2:0]))
		else $error("select not stored");
	index_read_a: assert property (reg_rd && reg_addr == OFF_INDEX_ADDR |=>
		reg_rdata == $past(idx_reg))
		else $error("index readback");
	deep_index_a: assert property (reg_rd && reg_addr == OFF_INDEX_DATA &&
		idx_reg > 8'h0F |=> reg_rdata == 8'h00)
		else $error("deep index read");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
endmodule

// *** tb/video_source_model.sv ***
// external video source: pixel enables over a 16-step raster
`timescale 1ns/1ps
module video_source_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	output logic ext_pclk_en,
	output logic ext_de,
	output logic ext_hs,
	output logic ext_vs
);
	logic [3:0] cnt;
	always @(negedge clk or negedge rst_n)
		if (!rst_n)
		begin
			cnt <= 4'h0;
			ext_pclk_en <= 1'b0;
		end
		else
		begin
			ext_pclk_en <= slow ? !ext_pclk_en : 1'b1;
			cnt <= cnt + {3'h0, ext_pclk_en};
		end
	// syncs and enable change only between steps, so every sampled step sees a stable raster
	assign ext_de = cnt[3];
	assign ext_hs = cnt[1:0] == 2'h0;
	assign ext_vs = cnt < 4'h2;
endmodule

// *** tb/video_test_pattern_control_bench.sv ***
// self-checking bench for the pattern control block
`timescale 1ns/1ps
module video_test_pattern_control_bench;
	import pattern_ctrl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic slow = 1'b0;
	logic [23:0] pattern_rgb = 24'h00_0000;
	logic [7:0] reg_rdata;
	logic ext_pclk_en, ext_de, ext_hs, ext_vs, pix_valid, pix_de, pix_hs, pix_vs, last_en, last_de;
	logic [23:0] pix_rgb, last_rgb;
	logic last_hs, last_vs;
	logic [2:0] pattern_sel;
	logic [7:0] v;
	logic [7:0] mem [16];
	logic [7:0] tim [13] = '{8'h08, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00,
		8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
	int seed = 42424;
	int num_errors = 0;
	int n_checks = 0;
	int i, n, m, gap;
	always #5 clk = ~clk;
	video_source_model src_u (.clk(clk), .rst_n(rst_n), .slow(slow), .ext_pclk_en(ext_pclk_en),
		.ext_de(ext_de), .ext_hs(ext_hs), .ext_vs(ext_vs));
	video_test_pattern_control #(.DIV_RATIO(4)) dut_u (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .ext_pclk_en(ext_pclk_en), .ext_de(ext_de), .ext_hs(ext_hs),
		.ext_vs(ext_vs), .pattern_rgb(pattern_rgb), .pix_valid(pix_valid), .pix_de(pix_de),
		.pix_hs(pix_hs), .pix_vs(pix_vs), .pix_rgb(pix_rgb), .pattern_sel(pattern_sel));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// write strobe is left high so index and data writes can go back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
	endtask
	task automatic wi(input logic [7:0] a, input logic [7:0] d);
		wr(OFF_INDEX_ADDR, a);
		wr(OFF_INDEX_DATA, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
		@(negedge clk);
	endtask
	// counts pixel steps and active steps over a window
	task automatic win(input int len);
		reg_wr = 1'b0;
		repeat (20) @(negedge clk);
		n = 0;
		m = 0;
		repeat (len)
		begin
			@(negedge clk);
			n += pix_valid;
			m += pix_valid & pix_de;
		end
	endtask
	task automatic pix_run(input logic inv);
		reg_wr = 1'b0;
		last_en = 1'b0;
		for (i = 0; i < 40; i++)
		begin
			@(negedge clk);
			if (last_en)
			begin
				chk(pix_rgb, last_rgb ^ {24{inv}});
				chk(pix_de, last_de);
				chk({pix_hs, pix_vs}, {last_hs, last_vs});
			end
			pattern_rgb = $random(seed);
			// record what the rising edge takes, after the source model has settled
			@(posedge clk);
			last_en = ext_pclk_en;
			last_de = ext_de;
			last_hs = ext_hs;
			last_vs = ext_vs;
			last_rgb = pattern_rgb;
		end
		@(negedge clk);
	endtask
	function automatic logic [2:0] nxt(input logic [2:0] p);
		logic [2:0] q;
		q = p + 3'h1;
		for (int k = 0; k < 8 && !m[q]; k++)
			q++;
		return q;
	endfunction
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		rd(OFF_INDEX_ADDR, 8'h00);
		rd(OFF_INDEX_DATA, 8'h00);
		wr(8'h70, 8'h5A);
		rd(8'h70, 8'h00);
		v = $random(seed);
		wr(OFF_INDEX_ADDR, v);
		rd(OFF_INDEX_ADDR, v);
		wi(8'h20, v);
		rd(OFF_INDEX_DATA, 8'h00);
		for (i = 0; i < 16; i++)
		begin
			mem[i] = $random(seed);
			wi(i[7:0], mem[i]);
		end
		for (i = 0; i < 16; i++)
		begin
			wr(OFF_INDEX_ADDR, i[7:0]);
			rd(OFF_INDEX_DATA, mem[i]);
		end
		wr(OFF_PATGEN_CFG, 8'h00);
		pix_run(1'b0);
		slow = 1'b1;
		wr(OFF_PATGEN_CFG, 8'h02);
		pix_run(1'b1);
		for (i = 0; i < 13; i++)
			wi(i[7:0], tim[i]);
		wr(OFF_PATGEN_CFG, 8'h04);
		win(128);
		chk(n, 32);
		chk(m, 8);
		wr(OFF_PATGEN_CFG, 8'h0C);
		win(128);
		chk(n, 64);
		slow = 1'b0;
		m = 8'h25;
		wi(IND_FRAME_TIME, 8'h02);
		wi(IND_PAT_ENABLE, 8'h25);
		wi(IND_PAT_SELECT, 8'h00);
		wr(OFF_PATGEN_CFG, 8'h01);
		reg_wr = 1'b0;
		v = 8'h00;
		gap = 0;
		n = 0;
		for (i = 0; i < 200; i++)
		begin
			@(negedge clk);
			gap++;
			if (pattern_sel !== v[2:0])
			begin
				chk(pattern_sel, nxt(v[2:0]));
				if (n > 0)
					chk(gap, 32);
				n++;
				gap = 0;
				v[2:0] = pattern_sel;
			end
		end
		chk(n >= 5, 1'b1);
		wr(OFF_PATGEN_CFG, 8'h00);
		// an auto step may still land on the edge that clears the bit
		v[2:0] = pattern_sel;
		win(100);
		chk(pattern_sel, v[2:0]);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		chk({reg_rdata, pattern_sel}, 11'h000);
		rst_n = 1'b1;
		rd(OFF_INDEX_ADDR, 8'h00);
		wrap_up();
	end
endmodule
bind video_test_pattern_control video_test_pattern_control_assertions chk_u (.clk(clk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .ext_pclk_en(ext_pclk_en), .ext_de(ext_de), .pattern_rgb(pattern_rgb),
	.pix_valid(pix_valid), .pix_de(pix_de), .pix_rgb(pix_rgb), .pattern_sel(pattern_sel));
